// ==== inc/timer8_pkg.sv ====
// package: constants and types for the eight-bit dual compare timer
package timer8_pkg;

	localparam int          COUNT_W      = 8;
	localparam logic [7:0]  COUNT_BOTTOM = 8'h00;
	localparam logic [7:0]  COUNT_MAX    = 8'hff;
	localparam logic [7:0]  COUNT_RESET  = 8'h00;
	localparam logic [7:0]  COUNT_ONE    = 8'h01;
	localparam logic [2:0]  SEL_STOP     = 3'h0;
	localparam logic [2:0]  SEL_DIRECT   = 3'h1;
	localparam logic [2:0]  SEL_PRE_LAST = 3'h5;
	localparam logic [2:0]  SEL_EXT_FALL = 3'h6;
	localparam logic [2:0]  SEL_EXT_RISE = 3'h7;
	localparam logic [1:0]  COM_NONE     = 2'h0;
	localparam logic [1:0]  COM_TOGGLE   = 2'h1;
	localparam logic [1:0]  COM_CLEAR    = 2'h2;
	localparam logic [1:0]  COM_SET      = 2'h3;

	// waveform mode encodings
	typedef enum logic [2:0] {
		WM_NORMAL    = 3'b000,
		WM_PC_MAX    = 3'b001,
		WM_CLEAR_A   = 3'b010,
		WM_FAST_MAX  = 3'b011,
		WM_RSVD4     = 3'b100,
		WM_PC_A      = 3'b101,
		WM_RSVD6     = 3'b110,
		WM_FAST_A    = 3'b111
	} waveform_mode_e;

	// first control register fields
	typedef struct packed {
		logic [1:0] compare_output_mode_a;
		logic [1:0] compare_output_mode_b;
		logic       waveform_mode_bit1;
		logic       waveform_mode_bit0;
	} timer_control_first_s;

	// second control register fields
	typedef struct packed {
		logic       force_match_strobe_a;
		logic       force_match_strobe_b;
		logic       waveform_mode_bit2;
		logic [2:0] tick_source_select;
	} timer_control_second_s;

	// flag and mask layout
	typedef struct packed {
		logic match_flag_b;
		logic match_flag_a;
		logic overflow_flag;
	} timer_flags_s;

	// software strobes with data
	typedef struct packed {
		logic       count_wr;
		logic       cmp_a_wr;
		logic       cmp_b_wr;
		logic [7:0] wdata;
	} timer_write_s;

endpackage : timer8_pkg

// ==== hw/timer8_compare_unit.sv ====
// one compare unit: buffered compare value, match detect, output state
`timescale 1ns/100ps
module timer8_compare_unit #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_in,
	input  wire logic             rst_n_in,
	input  wire logic             tick_in,
	input  wire logic [WIDTH-1:0] count_in,
	input  wire logic             wr_in,
	input  wire logic [WIDTH-1:0] wdata_in,
	input  wire logic             buffered_in,
	input  wire logic             update_in,
	input  wire logic             block_in,
	input  wire logic             pwm_in,
	input  wire logic             fast_in,
	input  wire logic             bottom_evt_in,
	input  wire logic [1:0]       mode_in,
	input  wire logic             force_in,
	output logic                  match_out,
	output logic [WIDTH-1:0]      active_out,
	output logic [WIDTH-1:0]      buffer_out,
	output logic                  state_out
);
	import timer8_pkg::*;

	logic [WIDTH-1:0] active_reg;
	logic [WIDTH-1:0] buffer_reg;
	logic             state_reg;
	logic             state_next;

	initial begin
		if (WIDTH < 1) $error("compare unit width must be positive");
	end

	// match, gated by the write block
	assign match_out  = (count_in == active_reg) && !block_in;
	assign active_out = active_reg;
	assign buffer_out = buffer_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			buffer_reg <= '0;
		end else if (wr_in) begin
			buffer_reg <= wdata_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			active_reg <= '0;
		end else if (wr_in && !buffered_in) begin
			active_reg <= wdata_in;
		end else if (buffered_in && update_in) begin
			active_reg <= buffer_reg;
		end
	end

	always_comb begin
		state_next = state_reg;
		if (!pwm_in) begin
			if ((tick_in && match_out) || force_in) begin
				case (mode_in)
					COM_TOGGLE: state_next = !state_reg;
					COM_CLEAR:  state_next = 1'b0;
					COM_SET:    state_next = 1'b1;
					default:    state_next = state_reg;
				endcase
			end
		end else if (fast_in && tick_in) begin
			if (match_out) begin
				case (mode_in)
					COM_CLEAR: state_next = 1'b0;
					COM_SET:   state_next = 1'b1;
					default:   state_next = state_reg;
				endcase
			end else if (bottom_evt_in) begin
				case (mode_in)
					COM_CLEAR: state_next = 1'b1;
					COM_SET:   state_next = 1'b0;
					default:   state_next = state_reg;
				endcase
			end
		end else if (tick_in && match_out) begin
			case (mode_in)
				COM_CLEAR: state_next = !state_reg;
				COM_SET:   state_next = !state_reg;
				default:   state_next = state_reg;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign state_out = state_reg;

endmodule : timer8_compare_unit

// ==== hw/timer8_dual_compare_core.sv ====
// eight-bit timer core with tick select and two compare units
`timescale 1ns/100ps
module timer8_dual_compare_core #(
	parameter int PRESCALE_DIV = 8
) (
	input  wire logic                               CLK_IN,
	input  wire logic                               RST_N_IN,
	input  wire timer8_pkg::timer_control_first_s   CTRL_FIRST_IN,
	input  wire timer8_pkg::timer_control_second_s  CTRL_SECOND_IN,
	input  wire timer8_pkg::timer_flags_s           MASK_IN,
	input  wire timer8_pkg::timer_flags_s           FLAG_CLR_IN,
	input  wire timer8_pkg::timer_flags_s           INT_ACK_IN,
	input  wire timer8_pkg::timer_write_s           WRITE_IN,
	input  wire logic                               EXT_COUNT_IN,
	output logic [7:0]                              COUNT_VALUE_OUT,
	output logic [7:0]                              COMPARE_A_OUT,
	output logic [7:0]                              COMPARE_B_OUT,
	output timer8_pkg::timer_flags_s                FLAGS_OUT,
	output timer8_pkg::timer_flags_s                IRQ_OUT,
	output logic                                    COMPARE_OUT_A_OUT,
	output logic                                    COMPARE_OUT_B_OUT
);
	import timer8_pkg::*;

	// ----------------------------------------
	// reset and state
	// ----------------------------------------
	logic           rst_meta_reg;
	logic           rst_sync_reg;
	logic [7:0]     count_value_reg;
	logic [7:0]     count_value_next;
	logic           down_reg;
	logic           down_next;
	logic [15:0]    prescale_reg;
	logic           ext_prev_reg;
	logic           timer_tick;
	logic           block_reg;
	timer_flags_s   flags_reg;
	timer_flags_s   flags_set;
	waveform_mode_e waveform_mode;
	logic           pwm_mode;
	logic           fast_mode;
	logic           phase_mode;
	logic           buffered;
	logic [7:0]     top_value;
	logic           at_top;
	logic           at_bottom;
	logic           update_evt;
	logic           bottom_evt;
	logic           match_a;
	logic           match_b;
	logic [7:0]     active_a;
	logic [7:0]     active_b;
	logic [7:0]     buffer_a;
	logic [7:0]     buffer_b;
	logic           state_a;
	logic           state_b;

	initial begin
		if (PRESCALE_DIV < 1 || PRESCALE_DIV > 65535)
			$error("prescale divider out of range");
	end

	always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
		if (!RST_N_IN) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	// mode bits from two registers
	assign waveform_mode = waveform_mode_e'({
		CTRL_SECOND_IN.waveform_mode_bit2,
		CTRL_FIRST_IN.waveform_mode_bit1,
		CTRL_FIRST_IN.waveform_mode_bit0});
	assign fast_mode  = (waveform_mode == WM_FAST_MAX) ||
	                    (waveform_mode == WM_FAST_A);
	assign phase_mode = (waveform_mode == WM_PC_MAX) ||
	                    (waveform_mode == WM_PC_A);
	assign pwm_mode   = fast_mode || phase_mode;
	assign buffered   = pwm_mode;

	// top is max or compare A
	always_comb begin
		case (waveform_mode)
			WM_CLEAR_A, WM_PC_A, WM_FAST_A: top_value = active_a;
			default:                        top_value = COUNT_MAX;
		endcase
	end

	assign at_top    = (count_value_reg == top_value);
	assign at_bottom = (count_value_reg == COUNT_BOTTOM);

	// ----------------------------------------
	// tick select
	// ----------------------------------------
	// tick is single-cycle enable
	always_ff @(posedge CLK_IN or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			prescale_reg <= '0;
			ext_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= EXT_COUNT_IN;
			if (prescale_reg == 16'(PRESCALE_DIV - 1)) begin
				prescale_reg <= '0;
			end else begin
				prescale_reg <= prescale_reg + 16'h0001;
			end
		end
	end

	always_comb begin
		case (CTRL_SECOND_IN.tick_source_select)
			SEL_STOP:     timer_tick = 1'b0;
			SEL_DIRECT:   timer_tick = 1'b1;
			SEL_EXT_FALL: timer_tick = ext_prev_reg && !EXT_COUNT_IN;
			SEL_EXT_RISE: timer_tick = !ext_prev_reg && EXT_COUNT_IN;
			default:      timer_tick = (prescale_reg == '0);
		endcase
	end

	// ----------------------------------------
	// counter
	// ----------------------------------------
	// clear, count up or down per mode
	always_comb begin
		count_value_next = count_value_reg;
		down_next        = down_reg;
		if (timer_tick) begin
			if (phase_mode) begin
				if (!down_reg && at_top) begin
					down_next        = 1'b1;
					count_value_next = count_value_reg - COUNT_ONE;
				end else if (down_reg && at_bottom) begin
					down_next        = 1'b0;
					count_value_next = count_value_reg + COUNT_ONE;
				end else if (down_reg) begin
					count_value_next = count_value_reg - COUNT_ONE;
				end else begin
					count_value_next = count_value_reg + COUNT_ONE;
				end
			end else if ((fast_mode || waveform_mode == WM_CLEAR_A)
			             && at_top) begin
				count_value_next = COUNT_BOTTOM;
				down_next        = 1'b0;
			end else begin
				count_value_next = count_value_reg + COUNT_ONE;
				down_next        = 1'b0;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			count_value_reg <= COUNT_RESET;
			down_reg        <= 1'b0;
		end else if (WRITE_IN.count_wr) begin
			count_value_reg <= WRITE_IN.wdata;
		end else begin
			count_value_reg <= count_value_next;
			down_reg        <= down_next;
		end
	end

	always_ff @(posedge CLK_IN or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			block_reg <= 1'b0;
		end else if (WRITE_IN.count_wr) begin
			block_reg <= 1'b1;
		end else if (timer_tick) begin
			block_reg <= 1'b0;
		end
	end

	// update at top (fast or phase correct)
	assign update_evt = timer_tick &&
	                    (fast_mode ? at_top : (phase_mode && at_top));
	assign bottom_evt = timer_tick && at_top && fast_mode;

	// ----------------------------------------
	// compare units
	// ----------------------------------------
	// force only outside pwm
	timer8_compare_unit #(.WIDTH(COUNT_W)) u_cmp_a (
		.clk_in        (CLK_IN),
		.rst_n_in      (rst_sync_reg),
		.tick_in       (timer_tick),
		.count_in      (count_value_reg),
		.wr_in         (WRITE_IN.cmp_a_wr),
		.wdata_in      (WRITE_IN.wdata),
		.buffered_in   (buffered),
		.update_in     (update_evt),
		.block_in      (block_reg),
		.pwm_in        (pwm_mode),
		.fast_in       (fast_mode),
		.bottom_evt_in (bottom_evt),
		.mode_in       (CTRL_FIRST_IN.compare_output_mode_a),
		.force_in      (CTRL_SECOND_IN.force_match_strobe_a && !pwm_mode),
		.match_out     (match_a),
		.active_out    (active_a),
		.buffer_out    (buffer_a),
		.state_out     (state_a)
	);

	timer8_compare_unit #(.WIDTH(COUNT_W)) u_cmp_b (
		.clk_in        (CLK_IN),
		.rst_n_in      (rst_sync_reg),
		.tick_in       (timer_tick),
		.count_in      (count_value_reg),
		.wr_in         (WRITE_IN.cmp_b_wr),
		.wdata_in      (WRITE_IN.wdata),
		.buffered_in   (buffered),
		.update_in     (update_evt),
		.block_in      (block_reg),
		.pwm_in        (pwm_mode),
		.fast_in       (fast_mode),
		.bottom_evt_in (bottom_evt),
		.mode_in       (CTRL_FIRST_IN.compare_output_mode_b),
		.force_in      (CTRL_SECOND_IN.force_match_strobe_b && !pwm_mode),
		.match_out     (match_b),
		.active_out    (active_b),
		.buffer_out    (buffer_b),
		.state_out     (state_b)
	);

	// ----------------------------------------
	// flags
	// ----------------------------------------
	// overflow point per mode
	always_comb begin
		flags_set.match_flag_a  = timer_tick && match_a;
		flags_set.match_flag_b  = timer_tick && match_b;
		if (phase_mode) begin
			flags_set.overflow_flag = timer_tick && down_reg && at_bottom;
		end else if (fast_mode) begin
			flags_set.overflow_flag = timer_tick && at_top;
		end else begin
			flags_set.overflow_flag = timer_tick &&
			                          (count_value_reg == COUNT_MAX);
		end
	end

	// cleared by ack or one, set wins
	always_ff @(posedge CLK_IN or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			flags_reg <= '0;
		end else begin
			flags_reg <= flags_set |
			             (flags_reg & ~(FLAG_CLR_IN | INT_ACK_IN));
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	// masked interrupt requests
	always_ff @(posedge CLK_IN or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			COUNT_VALUE_OUT   <= COUNT_RESET;
			COMPARE_A_OUT     <= COUNT_RESET;
			COMPARE_B_OUT     <= COUNT_RESET;
			FLAGS_OUT         <= '0;
			IRQ_OUT           <= '0;
			COMPARE_OUT_A_OUT <= 1'b0;
			COMPARE_OUT_B_OUT <= 1'b0;
		end else begin
			COUNT_VALUE_OUT   <= count_value_reg;
			COMPARE_A_OUT     <= buffered ? buffer_a : active_a;
			COMPARE_B_OUT     <= buffered ? buffer_b : active_b;
			FLAGS_OUT         <= flags_reg;
			IRQ_OUT           <= flags_reg & MASK_IN;
			COMPARE_OUT_A_OUT <= state_a;
			COMPARE_OUT_B_OUT <= state_b;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// stopped counter holds
	property p_stop_hold;
		@(posedge CLK_IN) disable iff (!rst_sync_reg)
		(CTRL_SECOND_IN.tick_source_select == SEL_STOP &&
		 !WRITE_IN.count_wr) |=> $stable(count_value_reg);
	endproperty
	a_stop_hold: assert property (p_stop_hold)
		else $error("counter moved while stopped");

	property p_write_wins;
		@(posedge CLK_IN) disable iff (!rst_sync_reg)
		WRITE_IN.count_wr |=> count_value_reg == $past(WRITE_IN.wdata);
	endproperty
	a_write_wins: assert property (p_write_wins)
		else $error("counter write lost");

	// normal wraps to zero with overflow
	property p_normal_wrap;
		@(posedge CLK_IN) disable iff (!rst_sync_reg)
		(waveform_mode == WM_NORMAL && timer_tick && !WRITE_IN.count_wr &&
		 count_value_reg == COUNT_MAX)
		|=> count_value_reg == COUNT_BOTTOM && flags_reg.overflow_flag;
	endproperty
	a_normal_wrap: assert property (p_normal_wrap)
		else $error("normal wrap wrong");

	property p_match_flag;
		@(posedge CLK_IN) disable iff (!rst_sync_reg)
		(timer_tick && match_a) |=> flags_reg.match_flag_a;
	endproperty
	a_match_flag: assert property (p_match_flag)
		else $error("match flag not set");

	sequence s_write_then_tick;
		WRITE_IN.count_wr ##1 (!WRITE_IN.count_wr && timer_tick);
	endsequence
	property p_block;
		@(posedge CLK_IN) disable iff (!rst_sync_reg)
		s_write_then_tick |=> !$rose(flags_reg.match_flag_a);
	endproperty
	a_block: assert property (p_block)
		else $error("match not blocked after write");

	property p_ctc_clear;
		@(posedge CLK_IN) disable iff (!rst_sync_reg)
		(waveform_mode == WM_CLEAR_A && timer_tick && at_top &&
		 !WRITE_IN.count_wr) |=> count_value_reg == COUNT_BOTTOM;
	endproperty
	a_ctc_clear: assert property (p_ctc_clear)
		else $error("clear on match failed");

	// flag clear input clears flag when no set
	property p_flag_clear;
		@(posedge CLK_IN) disable iff (!rst_sync_reg)
		(FLAG_CLR_IN.match_flag_b && !flags_set.match_flag_b)
		|=> !flags_reg.match_flag_b;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("flag not cleared");

	property p_irq;
		@(posedge CLK_IN) disable iff (!rst_sync_reg)
		##1 IRQ_OUT == ($past(flags_reg) & $past(MASK_IN));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt output mismatch");

endmodule : timer8_dual_compare_core

// ==== verification/tb_timer8_dual_compare_core.sv ====
// testbench: self-checking bench for the eight-bit dual compare timer
`timescale 1ns/100ps
module tb_timer8_dual_compare_core;
	import timer8_pkg::*;

	logic                  clk_in;
	logic                  rst_n_in;
	timer_control_first_s  ctrl1;
	timer_control_second_s ctrl2;
	timer_flags_s          mask;
	timer_flags_s          fclr;
	timer_flags_s          ack;
	timer_write_s          wr;
	logic                  ext;
	logic [7:0]            count_out;
	logic [7:0]            cmp_a_out;
	logic [7:0]            cmp_b_out;
	timer_flags_s          flags_out;
	timer_flags_s          irq_out;
	logic                  out_a;
	logic                  out_b;
	int                    miscompares;
	int                    num_checks;
	int                    cycles;
	logic [31:0]           seed;
	logic [7:0]            c;
	logic [1:0]            com_tab [5];
	logic                  exp_st;

	timer8_dual_compare_core #(.PRESCALE_DIV(2)) u_dut (
		.CLK_IN            (clk_in),
		.RST_N_IN          (rst_n_in),
		.CTRL_FIRST_IN     (ctrl1),
		.CTRL_SECOND_IN    (ctrl2),
		.MASK_IN           (mask),
		.FLAG_CLR_IN       (fclr),
		.INT_ACK_IN        (ack),
		.WRITE_IN          (wr),
		.EXT_COUNT_IN      (ext),
		.COUNT_VALUE_OUT   (count_out),
		.COMPARE_A_OUT     (cmp_a_out),
		.COMPARE_B_OUT     (cmp_b_out),
		.FLAGS_OUT         (flags_out),
		.IRQ_OUT           (irq_out),
		.COMPARE_OUT_A_OUT (out_a),
		.COMPARE_OUT_B_OUT (out_b)
	);

	// --------------------------------------------------------------
	// clock and timeout
	// --------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			finish_test();
		end
	end

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction : rnd

	// expected output state after a match or force
	function automatic logic com_next(input logic [1:0] m, input logic s);
		case (m)
			COM_TOGGLE: return !s;
			COM_CLEAR:  return 1'b0;
			COM_SET:    return 1'b1;
			default:    return s;
		endcase
	endfunction : com_next

	task automatic check(input logic [7:0] seen, input logic [7:0] exp,
			input string what);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("FAIL %0t %s: saw %h want %h", $time, what, seen, exp);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
	endtask : cyc

	// which = {count, compare a, compare b}
	task automatic wr_reg(input logic [2:0] which, input logic [7:0] v);
		wr <= timer_write_s'({which, v});
		cyc(1);
		wr <= '0;
		cyc(4);
	endtask : wr_reg

	task automatic set_mode(input logic [2:0] m);
		ctrl1.waveform_mode_bit1 <= m[1];
		ctrl1.waveform_mode_bit0 <= m[0];
		ctrl2.waveform_mode_bit2 <= m[2];
		cyc(2);
	endtask : set_mode

	task automatic clr_flags(input timer_flags_s f, input logic by_ack);
		if (by_ack) ack <= f;
		else fclr <= f;
		cyc(1);
		ack <= '0;
		fclr <= '0;
		cyc(4);
	endtask : clr_flags

	// one pulse on the count pin gives one rising and one falling edge
	task automatic ticks(input int n);
		repeat (n) begin
			ext <= 1'b1;
			cyc(3);
			ext <= 1'b0;
			cyc(7);
		end
	endtask : ticks

	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : finish_test

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		seed = 32'd79;
		miscompares = 0;
		num_checks = 0;
		cycles = 0;
		rst_n_in = 1'b0;
		ctrl1 = '0;
		ctrl2 = '0;
		mask = '0;
		fclr = '0;
		ack = '0;
		wr = '0;
		ext = 1'b0;
		com_tab = '{COM_SET, COM_NONE, COM_TOGGLE, COM_CLEAR, COM_TOGGLE};
		exp_st = 1'b0;
		cyc(8);
		rst_n_in <= 1'b1;
		cyc(3);
		check(count_out, 8'h00, "reset count");
		check(8'(flags_out), 8'h00, "reset flags");
		check(8'({out_a, out_b}), 8'h00, "reset outputs");
		$display("test reset done");

		for (int i = 0; i < 4; i++) begin
			c = rnd();
			wr_reg(3'b100, c);
			check(count_out, c, "stopped write");
			ticks(2);
			check(count_out, c, "stopped holds");
		end
		for (int s = 6; s < 8; s++) begin
			ctrl2.tick_source_select <= 3'(s);
			wr_reg(3'b100, 8'h10);
			ticks(3);
			check(count_out, 8'h13, "pin edge ticks");
		end
		for (int s = 1; s < 6; s++) begin
			ctrl2.tick_source_select <= SEL_STOP;
			wr_reg(3'b100, 8'h00);
			ctrl2.tick_source_select <= 3'(s);
			cyc(20);
			ctrl2.tick_source_select <= SEL_STOP;
			cyc(3);
			check(8'(count_out != 8'h00), 8'h01, "internal ticks");
		end
		$display("test tick sources done");

		// wrap and overflow, mask, clear paths
		ctrl2.tick_source_select <= SEL_EXT_RISE;
		clr_flags(3'b111, 1'b0);
		mask <= 3'b001;
		for (int k = 0; k < 2; k++) begin
			wr_reg(3'b100, COUNT_MAX);
			ticks(1);
			check(count_out, COUNT_BOTTOM, "wrap");
			check(8'(flags_out), 8'h01, "overflow flag");
			check(8'(irq_out), 8'h01, "overflow irq");
			clr_flags(3'b001, k[0]);
			check(8'(flags_out), 8'h00, "flag cleared");
		end
		mask <= 3'b000;
		wr_reg(3'b100, COUNT_MAX);
		ticks(1);
		check(8'(irq_out), 8'h00, "masked irq");
		$display("test overflow done");

		// match timing, blocking after count write
		c = 8'h20 + {1'b0, rnd()} % 8'h80;
		wr_reg(3'b010, c);
		wr_reg(3'b001, c + 8'h01);
		check(cmp_a_out, c, "direct compare");
		wr_reg(3'b100, c - 8'h02);
		clr_flags(3'b111, 1'b0);
		ticks(2);
		check(8'(flags_out.match_flag_a), 8'h00, "early match");
		ticks(1);
		check(8'(flags_out.match_flag_a), 8'h01, "match a");
		check(8'(flags_out.match_flag_b), 8'h00, "early match b");
		ticks(1);
		check(8'(flags_out.match_flag_b), 8'h01, "match b");
		clr_flags(3'b111, 1'b0);
		wr_reg(3'b100, c);
		ticks(1);
		check(8'(flags_out.match_flag_a), 8'h00, "blocked match");
		ctrl2.tick_source_select <= SEL_DIRECT;
		wr_reg(3'b100, c);
		check(8'(flags_out.match_flag_a), 8'h00, "blocked direct");
		$display("test match done");

		// force through every output mode, no side effects
		ctrl2.tick_source_select <= SEL_STOP;
		clr_flags(3'b111, 1'b0);
		for (int i = 0; i < 5; i++) begin
			ctrl1.compare_output_mode_a <= com_tab[i];
			ctrl1.compare_output_mode_b <= com_tab[i];
			cyc(1);
			ctrl2.force_match_strobe_a <= 1'b1;
			ctrl2.force_match_strobe_b <= 1'b1;
			cyc(1);
			ctrl2.force_match_strobe_a <= 1'b0;
			ctrl2.force_match_strobe_b <= 1'b0;
			cyc(4);
			exp_st = com_next(com_tab[i], exp_st);
			check(8'({out_a, out_b}), {6'h0, {2{exp_st}}}, "force");
			check(8'(flags_out), 8'h00, "force flags");
			check(count_out, c + 8'h04, "force count");
		end
		// state kept across modes, force refused in pwm
		set_mode(3'(WM_FAST_MAX));
		ctrl2.force_match_strobe_a <= 1'b1;
		cyc(1);
		ctrl2.force_match_strobe_a <= 1'b0;
		cyc(4);
		set_mode(3'(WM_NORMAL));
		check(8'(out_a), 8'h01, "state kept");
		ctrl1.compare_output_mode_a <= COM_NONE;
		ctrl1.compare_output_mode_b <= COM_NONE;
		$display("test force done");

		// top from compare a, top from max
		ctrl2.tick_source_select <= SEL_EXT_RISE;
		set_mode(3'(WM_CLEAR_A));
		wr_reg(3'b010, 8'h05);
		for (int m = 0; m < 2; m++) begin
			set_mode(m[0] ? 3'(WM_FAST_A) : 3'(WM_CLEAR_A));
			wr_reg(3'b100, 8'h00);
			ticks(7);
			check(count_out, 8'h01, "top at compare a");
		end
		set_mode(3'(WM_FAST_MAX));
		wr_reg(3'b100, 8'hfd);
		ticks(3);
		check(count_out, COUNT_BOTTOM, "top at max");
		$display("test modes done");

		set_mode(3'(WM_NORMAL));
		wr_reg(3'b001, 8'h10);
		set_mode(3'(WM_FAST_MAX));
		wr_reg(3'b001, 8'h40);
		check(cmp_b_out, 8'h40, "buffer view");
		wr_reg(3'b100, 8'h0e);
		clr_flags(3'b111, 1'b0);
		ticks(3);
		check(8'(flags_out.match_flag_b), 8'h01, "old active");
		wr_reg(3'b100, 8'hfd);
		ticks(3);
		wr_reg(3'b100, 8'h3e);
		clr_flags(3'b111, 1'b0);
		ticks(3);
		check(8'(flags_out.match_flag_b), 8'h01, "copied at top");
		$display("test buffering done");

		set_mode(3'(WM_PC_MAX));
		wr_reg(3'b100, 8'hfe);
		ticks(3);
		check(count_out, 8'hfd, "down slope");
		wr_reg(3'b100, 8'h01);
		clr_flags(3'b111, 1'b0);
		ticks(2);
		check(count_out, 8'h01, "turn at bottom");
		check(8'(flags_out.overflow_flag), 8'h01, "bottom overflow");
		$display("test phase correct done");
		finish_test();
	end
endmodule : tb_timer8_dual_compare_core
